// ===== logic/wim_top.sv
// Purpose: Wake input filtering, status flags and measurement switch
// Assumes: Pins asynchronous; mode, sleep request and timer windows on I_CLK
// Notes:   Pins one and two give way to the measurement path while it is on
// Functional notes
// - Both input edges produce a wake event
// - Event raises interrupt in normal/stop, wake in sleep/fail-safe
// - Static sensing always, cyclic sensing only inside timer window
// - Event accepted only if input stays stable for the filter time
// - Filter field 00 short, 01 long, 10 timer A, 11 timer B
// - Per-pin wake enable bit written by software
// - Per-pin wake source flag for pins one to three
// - Level register shows live level, last sample in cyclic sensing
// - Fail pins as wake inputs use short static filter, secondary flags
// - Pull field 00 none, 01 pull-down, 10 pull-up
// - Pull field 11 follows the input level
// - Measurement off after reset, switch open
// - Switch closed only with measurement enabled in normal mode
// - Measurement disables pulls on first two pins and gates them
// - First two pins' settings writable but ignored while measuring
// - No status update for first two pins while measuring
// - Sleep with only pins one/two enabled while measuring sets fault, restart
// - Wake flags latch until cleared; level register never latches
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
module wim_top #(
    parameter int unsigned SHORT_CYC = wim_pkg::SHORT_FILTER_CYC,
    parameter int unsigned LONG_CYC  = wim_pkg::LONG_FILTER_CYC
) (
    input  wire logic                      I_CLK,
    input  wire logic                      I_ARST_N,
    input  wire logic                      I_CE,
    input  wire wim_pkg::wim_wb_req_s      I_WB_REQ,
    output logic [31:0]                    O_WB_DAT,
    output logic                           O_WB_ACK,
    input  wire logic [2:0]                I_WAKE_PIN,
    input  wire logic [1:0]                I_FAIL_PIN,
    input  wire wim_pkg::wim_mode_e        I_MODE,
    input  wire logic                      I_SLEEP_REQ,
    input  wire logic                      I_TMR_A_ON,
    input  wire logic                      I_TMR_B_ON,
    output logic [2:0]                     O_PULL_UP,
    output logic [2:0]                     O_PULL_DN,
    output logic                           O_MEAS_SW,
    output logic                           O_INT_REQ,
    output logic                           O_WAKE_REQ,
    output logic                           O_RESTART_REQ
);
    import wim_pkg::*;

    logic [NCH-1:0]            pins;
    logic [NCH-1:0]            ch_act;
    logic [NCH-1:0]            evt_vec;
    logic [NCH-1:0]            lvl_vec;
    logic [NCH-1:0][CNT_W-1:0] ch_lim;
    logic [5:0]                ctrl_reg, ctrl_next, pull_reg, pull_next, filt_reg, filt_next;
    logic [2:0]                stat_pri_reg, stat_pri_next, wk_set, clr_pri;
    logic [1:0]                stat_sec_reg, stat_sec_next, sec_set, clr_sec;
    logic                      fault_reg, fault_next;
    logic                      ack_reg, ack_next;
    logic [31:0]               rdat_reg, rdat_next;
    logic                      int_reg, int_next, wake_reg, wake_next, rst_reg, rst_next;
    logic                      msw_reg, msw_next;
    logic [2:0]                pu_reg, pu_next, pd_reg, pd_next;
    logic                      meas, wr, bad_sleep;

    assign pins = {I_FAIL_PIN, I_WAKE_PIN};
    assign meas = ctrl_reg[CTRL_MEAS_BIT];

    // Channel activity and filter length per input
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            ch_act[c] = 1'b1;
            ch_lim[c] = CNT_W'(SHORT_CYC);
            if (c < NWK) begin
                unique case (filt_reg[2*c +: 2])
                    FILT_LONG: ch_lim[c] = CNT_W'(LONG_CYC);
                    FILT_CYCA: ch_act[c] = I_TMR_A_ON;
                    FILT_CYCB: ch_act[c] = I_TMR_B_ON;
                    default:   ch_act[c] = 1'b1;
                endcase
                if (c < 2 && meas) begin
                    ch_act[c] = 1'b0;
                end
            end else begin
                ch_act[c] = ctrl_reg[CTRL_FAIL_LSB + c - NWK];
            end
        end
    end

    // Synchroniser and glitch filter, one per input
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic             s1_reg, s2_reg, lvl_reg, lvl_next, evt_reg, evt_next;
        logic [CNT_W-1:0] cnt_reg, cnt_next;

        // Any return to the old level before the limit clears the count
        always_comb begin
            lvl_next = lvl_reg;
            cnt_next = '0;
            evt_next = 1'b0;
            if (ch_act[c] && (s2_reg != lvl_reg)) begin
                if (cnt_reg == ch_lim[c] - 1'b1) begin
                    lvl_next = s2_reg;
                    evt_next = 1'b1;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
        end

        always_ff @(posedge I_CLK or negedge I_ARST_N) begin
            if (!I_ARST_N) begin
                s1_reg  <= 1'b0;
                s2_reg  <= 1'b0;
                lvl_reg <= 1'b0;
                evt_reg <= 1'b0;
                cnt_reg <= '0;
            end else if (I_CE) begin
                s1_reg  <= pins[c];
                s2_reg  <= s1_reg;
                lvl_reg <= lvl_next;
                evt_reg <= evt_next;
                cnt_reg <= cnt_next;
            end
        end

        assign evt_vec[c] = evt_reg;
        assign lvl_vec[c] = lvl_reg;
    end

    // Flag sources; a set in the clearing cycle wins
    assign wr      = I_WB_REQ.cyc && I_WB_REQ.stb && I_WB_REQ.we && !ack_reg && I_WB_REQ.sel[0];
    assign clr_pri = (wr && I_WB_REQ.adr == ADR_STAT_PRI) ? I_WB_REQ.dat[2:0] : 3'h0;
    assign clr_sec = (wr && I_WB_REQ.adr == ADR_STAT_SEC) ? I_WB_REQ.dat[1:0] : 2'h0;
    assign wk_set  = evt_vec[2:0] & ctrl_reg[2:0] & ~{1'b0, meas, meas};
    assign sec_set = evt_vec[4:3];
    // Only pins one or two can wake, and both are gated by measurement
    assign bad_sleep = meas && (ctrl_reg[1:0] != 2'h0) && !ctrl_reg[2]
                       && (ctrl_reg[CTRL_FAIL_LSB +: 2] == 2'h0);

    // Registers, bus answer and pin controls
    always_comb begin
        ctrl_next     = ctrl_reg;
        pull_next     = pull_reg;
        filt_next     = filt_reg;
        stat_pri_next = (stat_pri_reg & ~clr_pri) | wk_set;
        stat_sec_next = (stat_sec_reg & ~clr_sec) | sec_set;
        fault_next    = fault_reg;
        ack_next      = I_WB_REQ.cyc && I_WB_REQ.stb && !ack_reg;
        rdat_next     = 32'h0;
        int_next      = 1'b0;
        wake_next     = 1'b0;
        rst_next      = 1'b0;
        msw_next      = meas && (I_MODE == WIM_NORMAL);
        pu_next       = 3'h0;
        pd_next       = 3'h0;
        if (wr) begin
            unique case (I_WB_REQ.adr)
                ADR_CTRL:  ctrl_next = I_WB_REQ.dat[5:0];
                ADR_PULL:  pull_next = I_WB_REQ.dat[5:0];
                ADR_FILT:  filt_next = I_WB_REQ.dat[5:0];
                ADR_FAULT: fault_next = fault_reg & ~I_WB_REQ.dat[0];
                default:   ctrl_next = ctrl_reg;
            endcase
        end
        if (ack_next && !I_WB_REQ.we) begin
            unique case (I_WB_REQ.adr)
                ADR_CTRL:     rdat_next = {26'h0, ctrl_reg};
                ADR_PULL:     rdat_next = {26'h0, pull_reg};
                ADR_FILT:     rdat_next = {26'h0, filt_reg};
                ADR_STAT_PRI: rdat_next = {29'h0, stat_pri_reg};
                ADR_STAT_SEC: rdat_next = {30'h0, stat_sec_reg};
                ADR_LEVEL:    rdat_next = {29'h0, lvl_vec[2:0]};
                ADR_FAULT:    rdat_next = {31'h0, fault_reg};
                default:      rdat_next = 32'h0;
            endcase
        end
        if ((wk_set != 3'h0) || (sec_set != 2'h0)) begin
            int_next  = (I_MODE == WIM_NORMAL) || (I_MODE == WIM_STOP);
            wake_next = (I_MODE == WIM_SLEEP) || (I_MODE == WIM_FAILSAFE);
        end
        if (I_SLEEP_REQ && bad_sleep) begin
            fault_next = 1'b1;
            rst_next   = 1'b1;
        end
        for (int p = 0; p < NWK; p++) begin
            unique case (pull_reg[2*p +: 2])
                PULL_DOWN: pd_next[p] = 1'b1;
                PULL_UP:   pu_next[p] = 1'b1;
                PULL_AUTO: begin
                    pu_next[p] = lvl_vec[p];
                    pd_next[p] = !lvl_vec[p];
                end
                default:   pu_next[p] = 1'b0;
            endcase
            if (p < 2 && meas) begin
                pu_next[p] = 1'b0;
                pd_next[p] = 1'b0;
            end
        end
    end

    // Plain register stage; clock enable freezes everything
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            ctrl_reg     <= CTRL_RST;
            pull_reg     <= PULL_RST;
            filt_reg     <= FILT_RST;
            stat_pri_reg <= 3'h0;
            stat_sec_reg <= 2'h0;
            fault_reg    <= 1'b0;
            ack_reg      <= 1'b0;
            rdat_reg     <= 32'h0;
            int_reg      <= 1'b0;
            wake_reg     <= 1'b0;
            rst_reg      <= 1'b0;
            msw_reg      <= 1'b0;
            pu_reg       <= 3'h0;
            pd_reg       <= 3'h0;
        end else if (I_CE) begin
            ctrl_reg     <= ctrl_next;
            pull_reg     <= pull_next;
            filt_reg     <= filt_next;
            stat_pri_reg <= stat_pri_next;
            stat_sec_reg <= stat_sec_next;
            fault_reg    <= fault_next;
            ack_reg      <= ack_next;
            rdat_reg     <= rdat_next;
            int_reg      <= int_next;
            wake_reg     <= wake_next;
            rst_reg      <= rst_next;
            msw_reg      <= msw_next;
            pu_reg       <= pu_next;
            pd_reg       <= pd_next;
        end
    end

    assign O_WB_DAT      = rdat_reg;
    assign O_WB_ACK      = ack_reg;
    assign O_INT_REQ     = int_reg;
    assign O_WAKE_REQ    = wake_reg;
    assign O_RESTART_REQ = rst_reg;
    assign O_MEAS_SW     = msw_reg;
    assign O_PULL_UP     = pu_reg;
    assign O_PULL_DN     = pd_reg;

    // Checks on the block's own behaviour
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_ARST_N);

    chk_meas_switch: assert property (
        I_CE |=> O_MEAS_SW == ($past(meas) && $past(I_MODE) == WIM_NORMAL))
        else $error("measure switch state wrong");
    chk_pull_gated: assert property (
        I_CE && meas |=> (O_PULL_UP[1:0] == 2'h0) && (O_PULL_DN[1:0] == 2'h0))
        else $error("pull active on gated pin");
    chk_gated_stat: assert property (
        I_CE && meas |=> (stat_pri_reg[1:0] & ~$past(stat_pri_reg[1:0])) == 2'h0)
        else $error("gated pin flag set");
    chk_filter_time: assert property (
        $past(I_CE) && evt_vec[2] |-> $past(g_ch[2].cnt_reg) == $past(ch_lim[2]) - 1'b1)
        else $error("event before filter time");
    chk_edge_level: assert property (
        $past(I_CE) && evt_vec[2] |-> lvl_vec[2] != $past(lvl_vec[2]))
        else $error("event without level change");
    chk_flag_latch: assert property (
        I_CE && stat_pri_reg[2] && !clr_pri[2] |=> stat_pri_reg[2])
        else $error("wake flag lost");
    chk_flag_record: assert property (
        I_CE && evt_vec[2] && ctrl_reg[2] |=> stat_pri_reg[2])
        else $error("wake flag not set");
    chk_enable_block: assert property (
        I_CE && !stat_pri_reg[2] && !ctrl_reg[2] |=> !stat_pri_reg[2])
        else $error("disabled pin set flag");
    chk_bad_sleep: assert property (
        I_CE && I_SLEEP_REQ && bad_sleep |=> O_RESTART_REQ && fault_reg)
        else $error("restart not requested");
    chk_int_mode: assert property (
        $past(I_CE) && O_INT_REQ |-> $past(I_MODE) == WIM_NORMAL || $past(I_MODE) == WIM_STOP)
        else $error("interrupt outside normal or stop");
    chk_wake_mode: assert property (
        $past(I_CE) && O_WAKE_REQ |-> $past(I_MODE) == WIM_SLEEP || $past(I_MODE) == WIM_FAILSAFE)
        else $error("wake request outside sleep or fail-safe");

    // Gated and cyclic channels must hold their level, or software sees a false edge
    chk_level_hold: assert property (
        I_CE && meas |=> lvl_vec[1:0] == $past(lvl_vec[1:0]))
        else $error("gated pin level moved");
    chk_cyclic_hold: assert property (
        I_CE && filt_reg[5:4] == FILT_CYCA && !I_TMR_A_ON |=> lvl_vec[2] == $past(lvl_vec[2]))
        else $error("level moved outside timer window");
    chk_pull_auto: assert property (
        I_CE && !meas && pull_reg[1:0] == PULL_AUTO |=> O_PULL_UP[0] == $past(lvl_vec[0]))
        else $error("auto pull does not follow level");
    chk_sec_record: assert property (
        I_CE && evt_vec[3] && ctrl_reg[CTRL_FAIL_LSB] |=> stat_sec_reg[0])
        else $error("fail pin wake flag not set");

    cov_fail_wake:  cover property (I_CE && sec_set != 2'h0 ##1 stat_sec_reg != 2'h0);
    cov_sleep_wake: cover property (O_WAKE_REQ);
    cov_restart:    cover property (O_RESTART_REQ);
    cov_auto_pull:  cover property (pull_reg[5:4] == PULL_AUTO ##[1:20] $rose(O_PULL_UP[2]));
    cov_measure:    cover property (O_MEAS_SW ##1 !O_MEAS_SW);
endmodule

// ===== logic/wim_pkg.sv
// Purpose: Shared constants and types of the wake input monitor
// Assumes: 100 MHz core clock
// Notes:   Offsets are byte addresses on a 32-bit Wishbone bus
package wim_pkg;
    // Clock and filter timing
    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned SHORT_FILTER_NS  = 16000;
    localparam int unsigned LONG_FILTER_NS   = 64000;
    localparam int unsigned SHORT_FILTER_CYC = SHORT_FILTER_NS / CLK_PERIOD_NS;
    localparam int unsigned LONG_FILTER_CYC  = LONG_FILTER_NS / CLK_PERIOD_NS;
    localparam int          CNT_W            = 13;
    localparam int          NWK              = 3;
    localparam int          NCH              = 5;
    // Register offsets
    localparam logic [7:0] ADR_CTRL     = 8'h00;
    localparam logic [7:0] ADR_PULL     = 8'h04;
    localparam logic [7:0] ADR_FILT     = 8'h08;
    localparam logic [7:0] ADR_STAT_PRI = 8'h0c;
    localparam logic [7:0] ADR_STAT_SEC = 8'h10;
    localparam logic [7:0] ADR_LEVEL    = 8'h14;
    localparam logic [7:0] ADR_FAULT    = 8'h18;
    // Control field positions
    localparam int CTRL_MEAS_BIT = 3;
    localparam int CTRL_FAIL_LSB = 4;
    // Reset values
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [5:0] PULL_RST = 6'h00;
    localparam logic [5:0] FILT_RST = 6'h00;
    // Field codes
    localparam logic [1:0] PULL_DOWN = 2'h1;
    localparam logic [1:0] PULL_UP   = 2'h2;
    localparam logic [1:0] PULL_AUTO = 2'h3;
    localparam logic [1:0] FILT_LONG = 2'h1;
    localparam logic [1:0] FILT_CYCA = 2'h2;
    localparam logic [1:0] FILT_CYCB = 2'h3;

    typedef enum logic [1:0] {WIM_NORMAL, WIM_STOP, WIM_SLEEP, WIM_FAILSAFE} wim_mode_e;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wim_wb_req_s;
endpackage

// ===== tb/wim_switch_model.sv
// Purpose: External switch contacts and board ties on the wake pins
// Assumes: A closed contact overrides the internal pull sources
// Notes:   An open pin with no pull reads low through its board tie
`timescale 1ns/1ns
module wim_switch_model (
    input  wire logic [2:0] i_closed,
    input  wire logic [2:0] i_level,
    input  wire logic [2:0] i_pull_up,
    input  wire logic [2:0] i_pull_dn,
    output logic      [2:0] o_pin
);
    // Contact wins; an open pin sits at whatever the enabled pull gives
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            o_pin[k] = i_closed[k] ? i_level[k] : (i_pull_up[k] & ~i_pull_dn[k]);
        end
    end
endmodule

// ===== tb/test_wim_top.sv
// Purpose: Self-checking bench for the wake input monitor
// Assumes: Filter counts shortened to 8 and 32 cycles
// Notes:   Pins held well past the filter before any flag is read back
`timescale 1ns/1ns
module test_wim_top;
    import wim_pkg::*;
    logic        clk, arst_n, sleep_req, tmr_a, tmr_b, ce;
    logic [1:0]  fail_pin;
    logic [2:0]  closed, lvl, pin, pu, pd;
    logic [31:0] rdat, rnd;
    logic        ack, meas_sw, int_req, wake_req, restart;
    wim_wb_req_s req;
    wim_mode_e   mode;
    int          mismatches, tests_run, cycles, ints, wakes;

    wim_switch_model wim_switch_model_i (.i_closed(closed), .i_level(lvl),
        .i_pull_up(pu), .i_pull_dn(pd), .o_pin(pin));
    wim_top #(.SHORT_CYC(8), .LONG_CYC(32)) wim_top_i (.I_CLK(clk), .I_ARST_N(arst_n),
        .I_CE(ce), .I_WB_REQ(req), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_WAKE_PIN(pin),
        .I_FAIL_PIN(fail_pin), .I_MODE(mode), .I_SLEEP_REQ(sleep_req), .I_TMR_A_ON(tmr_a),
        .I_TMR_B_ON(tmr_b), .O_PULL_UP(pu), .O_PULL_DN(pd), .O_MEAS_SW(meas_sw),
        .O_INT_REQ(int_req), .O_WAKE_REQ(wake_req), .O_RESTART_REQ(restart));

    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Pulse counters and hang guard
    always @(posedge clk) begin
        cycles++;
        if (int_req === 1'b1) ints++;
        if (wake_req === 1'b1) wakes++;
        if (cycles > 20000) begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    // One classic cycle; held until ack is sampled, then released
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk);
        req <= '{1'b1, 1'b1, we, a, 4'h1, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        req <= '0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk($sformatf("reg %h", a), e, q);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Expected {up, dn} for one pull field and a settled level
    function automatic logic [1:0] pull_exp(input logic [1:0] c, input logic l);
        return (c == PULL_AUTO) ? {l, ~l} : {c[1], c[0]};
    endfunction

    task automatic report_and_stop();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        int n;
        arst_n = 1'b0; req = '0; mode = WIM_NORMAL; sleep_req = 1'b0; tmr_a = 1'b0;
        tmr_b = 1'b0; fail_pin = 2'h0; closed = 3'h7; lvl = 3'h0;
        ce = 1'b1;
        void'($urandom(59));
        wait_cyc(5);
        arst_n <= 1'b1;
        for (int a = 0; a <= 8'h1c; a += 4) rd(a[7:0], 32'h0);
        chk("meas_sw", 1'b0, meas_sw);
        wr(ADR_CTRL, 32'h07);
        for (int e = 0; e < 2; e++) begin
            n = ints;
            lvl[0] <= ~lvl[0];
            wait_cyc(16);
            chk("int", n + 1, ints);
            rd(ADR_STAT_PRI, 32'h1);
            rd(ADR_LEVEL, {29'h0, lvl});
            wr(ADR_STAT_PRI, 32'h1);
        end
        rd(ADR_STAT_PRI, 32'h0);
        lvl[1] <= 1'b1;
        wait_cyc($urandom_range(1, 5));
        lvl[1] <= 1'b0;
        wait_cyc(16);
        rd(ADR_STAT_PRI, 32'h0);
        wr(ADR_FILT, 32'h04);
        lvl[1] <= 1'b1;
        wait_cyc(20);
        lvl[1] <= 1'b0;
        wait_cyc(40);
        rd(ADR_STAT_PRI, 32'h0);
        lvl[1] <= 1'b1;
        wait_cyc(45);
        rd(ADR_STAT_PRI, 32'h2);
        // Software keeps the high-side supply on the same timer as the pin
        for (int c = 2; c < 4; c++) begin
            wr(ADR_FILT, c << 4);
            lvl[2] <= ~lvl[2];
            wait_cyc(20);
            rd(ADR_LEVEL, {29'h0, ~lvl[2], lvl[1:0]});
            if (c == 2) tmr_a <= 1'b1;
            else tmr_b <= 1'b1;
            wait_cyc(16);
            rd(ADR_LEVEL, {29'h0, lvl});
            tmr_a <= 1'b0;
            tmr_b <= 1'b0;
        end
        rd(ADR_STAT_PRI, 32'h6);
        wr(ADR_STAT_PRI, 32'h7);
        wr(ADR_FILT, 32'h0);
        mode <= WIM_SLEEP;
        n = wakes;
        lvl[2] <= 1'b1;
        wait_cyc(16);
        chk("wake", n + 1, wakes);
        rd(ADR_STAT_PRI, 32'h4);
        mode <= WIM_NORMAL;
        wr(ADR_CTRL, 32'h03);
        wr(ADR_STAT_PRI, 32'h4);
        lvl[2] <= 1'b0;
        wait_cyc(16);
        rd(ADR_STAT_PRI, 32'h0);
        rd(ADR_LEVEL, {29'h0, lvl});
        for (int c = 0; c < 4; c++) begin
            rnd = $urandom;
            wr(ADR_PULL, {26'h0, c[1:0], rnd[3:0]});
            wait_cyc(3);
            for (int k = 0; k < 3; k++) begin
                chk("pull", pull_exp(k == 2 ? c[1:0] : rnd[2*k +: 2], lvl[k]),
                    {pu[k], pd[k]});
            end
        end
        closed[2] <= 1'b0;
        wait_cyc(16);
        rd(ADR_LEVEL, {29'h0, lvl});
        closed[2] <= 1'b1;
        wr(ADR_CTRL, 32'h0f);
        wait_cyc(2);
        chk("meas_sw", 1'b1, meas_sw);
        chk("pull12", 4'h0, {pu[1:0], pd[1:0]});
        lvl[0] <= 1'b1;
        wait_cyc(16);
        rd(ADR_STAT_PRI, 32'h0);
        rd(ADR_LEVEL, {29'h0, lvl[2:1], 1'b0});
        mode <= WIM_STOP;
        wait_cyc(3);
        chk("meas_sw", 1'b0, meas_sw);
        mode <= WIM_NORMAL;
        wr(ADR_CTRL, 32'h0b);
        sleep_req <= 1'b1;
        @(posedge clk);
        sleep_req <= 1'b0;
        @(posedge clk);
        chk("restart", 1'b1, restart);
        rd(ADR_FAULT, 32'h1);
        wr(ADR_CTRL, 32'h10);
        fail_pin <= 2'h1;
        wait_cyc(16);
        rd(ADR_STAT_SEC, 32'h1);
        // Clock enable low freezes the synchronisers, so the edge must wait
        n = ints;
        ce <= 1'b0;
        fail_pin <= 2'h0;
        wait_cyc(20);
        chk("ce_hold", n, ints);
        ce <= 1'b1;
        wait_cyc(16);
        chk("ce_run", n + 1, ints);
        report_and_stop();
    end
endmodule
